// >>> core/adc_conv_setup_cmd_decoder.sv
`timescale 1ns/1ps
`include "adc_cmd_params.svh"
module adc_conv_setup_cmd_decoder
	import adc_cmd_pkg::*;
#(
	parameter int NUM_CH  = 16,
	parameter int INT_DIV = `INT_DIV_DEF,
	parameter int REP_W   = 5
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             sclk,
	input  wire logic             cs_n,
	input  wire logic             din,
	input  wire logic             convert_start_pin_n,
	input  wire logic [7:0]       pair_en,
	input  wire logic [REP_W-1:0] repeat_count,
	input  wire logic             ref_keep_on,
	input  wire logic             conv_ack,
	output logic                  conv_req,
	output logic [3:0]            conv_chan,
	output logic                  conv_temp,
	output logic                  ref_en,
	output logic                  scan_busy,
	output logic                  scan_done,
	output logic                  acq_by_pin,
	output logic                  conv_clk_ext,
	output logic                  top_is_input,
	output logic [1:0]            vref_mode,
	output logic                  secondary_vref_neg,
	output logic [1:0]            pair_cfg_target,
	output logic                  setup_stb,
	output logic                  other_stb,
	output logic [7:0]            other_byte
);

	if (NUM_CH != 8 && NUM_CH != 12 && NUM_CH != 16) begin : g_bad_ch
		$error("NUM_CH must be 8, 12 or 16");
	end
	if (INT_DIV < 1 || INT_DIV > 255) begin : g_bad_div
		$error("INT_DIV out of range");
	end
	if (REP_W < 1 || REP_W > 8) begin : g_bad_rep
		$error("REP_W out of range");
	end

	localparam logic [3:0] TOP = 4'(NUM_CH - 1);
	localparam logic [7:0] DIV_LAST = 8'(INT_DIV - 1);

	logic [7:0]       rx_byte;
	logic             rx_tog;
	logic             edge_tog;
	logic [2:0]       byte_sync_r;
	logic [2:0]       edge_sync_r;
	logic [2:0]       pin_sync_r;
	logic             byte_evt;
	logic             sclk_tick;
	logic             pin_fall;
	logic             conv_wr;
	logic             setup_wr;
	logic             other_wr;
	logic [7:0]       conv_cmd_r;
	logic [7:0]       setup_r;
	logic             wr_start_r;
	logic [7:0]       div_r;
	logic             int_tick;
	logic             conv_tick;
	clk_mode_e        clk_mode;
	sweep_e           sweep;
	logic             convert_start_pin_role;
	logic             secondary_vref_pin_neg;
	logic [3:0]       chan_n;
	logic [3:0]       chan_eff;
	logic             start;
	logic             need_wait;
	logic             wake_go;
	logic [7:0]       wake_len;
	logic             wake_done;
	seq_state_e       state_r;
	sweep_e           sweep_r;
	logic [3:0]       cur_r;
	logic [3:0]       end_r;
	logic [REP_W-1:0] rep_r;
	logic             temp_pend_r;
	logic             req_r;
	logic [3:0]       req_chan_r;
	logic             req_temp_r;
	logic             ref_on_r;
	logic             done_r;
	logic             other_stb_r;
	logic [7:0]       other_byte_r;
	logic             setup_stb_r;

	function automatic logic chan_bad(input logic [3:0] c,
		input logic pin, input logic secondary_vref_pin);
		chan_bad = (c > TOP) || (c == TOP && pin) ||
			(c == TOP - 4'h1 && secondary_vref_pin);
	endfunction : chan_bad

	function automatic logic chan_ok(input logic [3:0] c,
		input logic [7:0] pairs, input logic pin, input logic secondary_vref_pin);
		if (pairs[c[3:1]]) begin
			chan_ok = !c[0] && !chan_bad({c[3:1], 1'b0}, pin, secondary_vref_pin) &&
				!chan_bad({c[3:1], 1'b1}, pin, secondary_vref_pin);
		end else begin
			chan_ok = !chan_bad(c, pin, secondary_vref_pin);
		end
	endfunction : chan_ok

	serial_byte_rx u_rx (
		.sclk     (sclk),
		.srst     (srst),
		.cs_n     (cs_n),
		.din      (din),
		.byte_q   (rx_byte),
		.byte_tog (rx_tog),
		.edge_tog (edge_tog)
	);

	// Bit 0 of each chain is the first stage and feeds only bit 1
	always_ff @(posedge clk) begin
		if (srst) begin
			byte_sync_r <= 3'h0;
			edge_sync_r <= 3'h0;
			pin_sync_r  <= 3'h7;
		end else begin
			byte_sync_r <= {byte_sync_r[1:0], rx_tog};
			edge_sync_r <= {edge_sync_r[1:0], edge_tog};
			pin_sync_r  <= {pin_sync_r[1:0], convert_start_pin_n};
		end
	end

	assign byte_evt  = byte_sync_r[1] ^ byte_sync_r[2];
	assign sclk_tick = edge_sync_r[1] ^ edge_sync_r[2];
	assign pin_fall  = pin_sync_r[2] & ~pin_sync_r[1];

	assign conv_wr  = byte_evt && rx_byte[`CMD_CONV_BIT];
	assign setup_wr = byte_evt && !rx_byte[`CMD_CONV_BIT] &&
		rx_byte[`CMD_SETUP_BIT];
	assign other_wr = byte_evt && !rx_byte[`CMD_CONV_BIT] &&
		!rx_byte[`CMD_SETUP_BIT];

	always_ff @(posedge clk) begin
		if (srst) begin
			conv_cmd_r <= `CONV_RST;
			setup_r    <= `SETUP_RST;
		end else begin
			if (conv_wr) begin
				conv_cmd_r <= rx_byte;
			end
			if (setup_wr) begin
				setup_r <= rx_byte;
			end
		end
	end

	// Unclaimed bytes leave as a strobe with the byte held until the next
	always_ff @(posedge clk) begin
		if (srst) begin
			other_stb_r  <= 1'b0;
			other_byte_r <= 8'h00;
			setup_stb_r  <= 1'b0;
		end else begin
			other_stb_r <= other_wr;
			setup_stb_r <= setup_wr;
			if (other_wr) begin
				other_byte_r <= rx_byte;
			end
		end
	end

	assign clk_mode = clk_mode_e'(setup_r[`SETUP_CLK_HI:`SETUP_CLK_LO]);
	assign sweep = sweep_e'(conv_cmd_r[`CONV_SWEEP_HI:`CONV_SWEEP_LO]);
	assign chan_n = conv_cmd_r[`CONV_CHAN_HI:`CONV_CHAN_LO];
	assign chan_eff = pair_en[chan_n[3:1]] ?
		{chan_n[3:1], 1'b0} : chan_n;
	assign convert_start_pin_role = !setup_r[`SETUP_CLK_HI];
	assign secondary_vref_pin_neg = setup_r[`SETUP_VREF_LO];

	// Write-started scans wait one cycle so the new byte is in place
	always_ff @(posedge clk) begin
		if (srst) begin
			wr_start_r <= 1'b0;
		end else begin
			wr_start_r <= conv_wr && setup_r[`SETUP_CLK_HI];
		end
	end

	assign start = state_r == ST_IDLE && (wr_start_r ||
		(pin_fall && !setup_r[`SETUP_CLK_HI]));

	// Free-running internal conversion clock
	always_ff @(posedge clk) begin
		if (srst || div_r == DIV_LAST) begin
			div_r <= 8'h00;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	assign int_tick = div_r == DIV_LAST;
	// Ticks are only honest while sclk stays under its ceiling
	assign conv_tick = clk_mode == CK_SCLK ? sclk_tick : int_tick;

	// External reference needs no wake unless the sensor asks for it
	assign need_wait = !ref_on_r && (conv_cmd_r[`CONV_TEMP_BIT] ||
		!setup_r[`SETUP_VREF_LO]);
	assign wake_len = conv_cmd_r[`CONV_TEMP_BIT] ?
		`TEMP_WAKE_CYC : `REF_WAKE_CYC;
	assign wake_go = start && need_wait;

	settle_timer #(.W(8)) u_wait (
		.clk   (clk),
		.srst  (srst),
		.start (wake_go),
		.len   (wake_len),
		.tick  (conv_tick),
		.busy  (),
		.done  (wake_done)
	);

	always_ff @(posedge clk) begin
		if (srst) begin
			state_r     <= ST_IDLE;
			sweep_r     <= SW_SINGLE;
			cur_r       <= 4'h0;
			end_r       <= 4'h0;
			rep_r       <= '0;
			temp_pend_r <= 1'b0;
			req_r       <= 1'b0;
			req_chan_r  <= 4'h0;
			req_temp_r  <= 1'b0;
			ref_on_r    <= 1'b0;
			done_r      <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (start) begin
					sweep_r     <= sweep;
					temp_pend_r <= conv_cmd_r[`CONV_TEMP_BIT];
					rep_r       <= sweep == SW_REPEAT ?
						repeat_count : REP_W'(1);
					case (sweep)
					SW_LOW_TO_N: begin
						cur_r <= 4'h0;
						end_r <= chan_n;
					end
					SW_N_TO_TOP: begin
						cur_r <= chan_eff;
						end_r <= TOP;
					end
					default: begin
						cur_r <= chan_eff;
						end_r <= chan_eff;
					end
					endcase
					if (need_wait) begin
						ref_on_r <= 1'b1;
						state_r  <= ST_WAKE;
					end else begin
						state_r <= ST_PICK;
					end
				end
			end
			ST_WAKE: begin
				if (wake_done) begin
					state_r <= ST_PICK;
				end
			end
			ST_PICK: begin
				if (temp_pend_r) begin
					req_r      <= 1'b1;
					req_temp_r <= 1'b1;
					state_r    <= ST_WAIT;
				end else if (chan_ok(cur_r, pair_en, convert_start_pin_role,
						secondary_vref_pin_neg)) begin
					req_r      <= 1'b1;
					req_chan_r <= cur_r;
					req_temp_r <= 1'b0;
					state_r    <= ST_WAIT;
				end else if (cur_r == end_r) begin
					state_r <= ST_IDLE;
					done_r  <= 1'b1;
					if (!ref_keep_on) begin
						ref_on_r <= 1'b0;
					end
				end else begin
					cur_r <= cur_r + 4'h1;
				end
			end
			ST_WAIT: begin
				if (conv_ack) begin
					req_r   <= 1'b0;
					state_r <= ST_PICK;
					if (req_temp_r) begin
						temp_pend_r <= 1'b0;
					end else if (sweep_r == SW_REPEAT &&
							rep_r > REP_W'(1)) begin
						rep_r <= rep_r - REP_W'(1);
					end else if (cur_r == end_r) begin
						state_r <= ST_IDLE;
						done_r  <= 1'b1;
						if (!ref_keep_on) begin
							ref_on_r <= 1'b0;
						end
					end else begin
						cur_r <= cur_r + 4'h1;
					end
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

	assign conv_req           = req_r;
	assign conv_chan          = req_chan_r;
	assign conv_temp          = req_temp_r;
	assign ref_en             = ref_on_r || ref_keep_on;
	assign scan_busy          = state_r != ST_IDLE;
	assign scan_done          = done_r;
	assign acq_by_pin         = clk_mode == CK_INT_PIN_ACQ;
	assign conv_clk_ext       = clk_mode == CK_SCLK;
	assign top_is_input       = setup_r[`SETUP_CLK_HI];
	assign vref_mode          =
		setup_r[`SETUP_VREF_HI:`SETUP_VREF_LO];
	assign secondary_vref_neg = secondary_vref_pin_neg;
	assign pair_cfg_target    =
		setup_r[`SETUP_PAIR_HI:`SETUP_PAIR_LO];
	assign setup_stb          = setup_stb_r;
	assign other_stb          = other_stb_r;
	assign other_byte         = other_byte_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_conv_write_decode: assert property (
		conv_wr |=> conv_cmd_r == $past(rx_byte))
		else $error("conversion byte not stored");

	chk_setup_write_decode: assert property (
		byte_evt && rx_byte[7:6] != 2'h1 |=> setup_r == $past(setup_r))
		else $error("setup register changed by a foreign byte");

	chk_other_byte_pass: assert property (
		other_wr |=> other_stb && other_byte == $past(rx_byte))
		else $error("unclaimed byte not passed on");

	chk_clk_mode_reset: assert property (
		@(posedge clk) disable iff (1'b0) srst |=> setup_r[5])
		else $error("upper clock-select bit not set by reset");

	chk_write_starts_scan: assert property (
		conv_wr && setup_r[5] && state_r == ST_IDLE
		|=> ##1 state_r != ST_IDLE)
		else $error("conversion write did not start a scan");

	chk_pin_starts_scan: assert property (
		pin_fall && !setup_r[5] && !wr_start_r && state_r == ST_IDLE
		|=> state_r != ST_IDLE)
		else $error("start pin pulse did not start a scan");

	chk_temp_goes_first: assert property (
		state_r == ST_PICK && temp_pend_r |=> conv_req && conv_temp)
		else $error("temperature not converted first");

	chk_skip_pin_chan: assert property (
		conv_req && !conv_temp
		|-> !chan_bad(conv_chan, convert_start_pin_role, secondary_vref_pin_neg))
		else $error("conversion issued on a pin-role channel");

	chk_pair_even_chan: assert property (
		conv_req && !conv_temp && pair_en[conv_chan[3:1]]
		|-> !conv_chan[0])
		else $error("odd member of a pair converted alone");

	chk_ext_ref_nowait: assert property (
		start && !ref_on_r && setup_r[2] && !conv_cmd_r[0]
		|=> state_r == ST_PICK)
		else $error("settling wait with external reference");

	chk_single_once_end: assert property (
		state_r == ST_WAIT && conv_ack && !req_temp_r &&
		sweep_r == SW_SINGLE |=> state_r == ST_IDLE && scan_done)
		else $error("single conversion did not end the scan");

	chk_ref_off_after: assert property (
		scan_done && !ref_keep_on |-> !ref_on_r)
		else $error("reference left on after the scan");

endmodule : adc_conv_setup_cmd_decoder

// >>> pkg/adc_cmd_params.svh
`ifndef ADC_CMD_PARAMS_SVH
`define ADC_CMD_PARAMS_SVH

// Command byte select bits
`define CMD_CONV_BIT   7
`define CMD_SETUP_BIT  6

// Conversion byte fields
`define CONV_CHAN_HI   6
`define CONV_CHAN_LO   3
`define CONV_SWEEP_HI  2
`define CONV_SWEEP_LO  1
`define CONV_TEMP_BIT  0

// Setup byte fields
`define SETUP_CLK_HI   5
`define SETUP_CLK_LO   4
`define SETUP_VREF_HI  3
`define SETUP_VREF_LO  2
`define SETUP_PAIR_HI  1
`define SETUP_PAIR_LO  0

// Reset values
`define CONV_RST       8'h80
`define SETUP_RST      8'h68

// Reference wake-up, in conversion clock cycles
`define REF_WAKE_CYC   8'hda
`define TEMP_WAKE_CYC  8'hf4

// Serial clock ceiling in clock mode 11, in kHz
`define SCLK_MAX_KHZ   4800

// Internal conversion clock divider default
`define INT_DIV_DEF    4

`endif

// >>> pkg/adc_cmd_pkg.sv
package adc_cmd_pkg;

	typedef enum logic [1:0] {
		CK_INT_PIN_START = 2'h0,
		CK_INT_PIN_ACQ   = 2'h1,
		CK_INT_WR_START  = 2'h2,
		CK_SCLK          = 2'h3
	} clk_mode_e;

	typedef enum logic [1:0] {
		SW_LOW_TO_N = 2'h0,
		SW_N_TO_TOP = 2'h1,
		SW_REPEAT   = 2'h2,
		SW_SINGLE   = 2'h3
	} sweep_e;

	// Gray along idle, wake, pick, wait
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAKE = 2'h1,
		ST_PICK = 2'h3,
		ST_WAIT = 2'h2
	} seq_state_e;

endpackage : adc_cmd_pkg

// >>> core/serial_byte_rx.sv
`timescale 1ns/1ps
module serial_byte_rx (
	input  wire logic       sclk,
	input  wire logic       srst,
	input  wire logic       cs_n,
	input  wire logic       din,
	output logic [7:0]      byte_q,
	output logic            byte_tog,
	output logic            edge_tog
);

	logic [2:0] bit_cnt_r;
	logic [6:0] shift_r;

	// The frame's own select ends a partial byte; sclk may stop after it
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_r <= 3'h0;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
		end
	end

	always_ff @(posedge sclk) begin
		shift_r <= {shift_r[5:0], din};
	end

	// Byte stays put for eight sclk edges, long enough for clk to take it
	always_ff @(posedge sclk or posedge srst) begin
		if (srst) begin
			byte_q   <= 8'h00;
			byte_tog <= 1'b0;
		end else if (!cs_n && bit_cnt_r == 3'h7) begin
			byte_q   <= {shift_r, din};
			byte_tog <= ~byte_tog;
		end
	end

	// One toggle per rising sclk edge: the external conversion clock
	always_ff @(posedge sclk or posedge srst) begin
		if (srst) begin
			edge_tog <= 1'b0;
		end else begin
			edge_tog <= ~edge_tog;
		end
	end

endmodule : serial_byte_rx

// >>> core/settle_timer.sv
`timescale 1ns/1ps
module settle_timer #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         start,
	input  wire logic [W-1:0] len,
	input  wire logic         tick,
	output logic              busy,
	output logic              done
);

	if (W < 2) begin : g_bad_w
		$error("settle_timer: W below 2");
	end

	logic [W-1:0] cnt_r;
	logic [W-1:0] len_r;
	logic [W-1:0] ticks_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r <= '0;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_r <= len;
				busy  <= 1'b1;
			end else if (busy && tick) begin
				if (cnt_r <= W'(1)) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_r <= cnt_r - W'(1);
				end
			end
		end
	end

	// Helper for the check below only
	always_ff @(posedge clk) begin
		if (srst) begin
			ticks_r <= '0;
			len_r   <= '0;
		end else if (start) begin
			ticks_r <= '0;
			len_r   <= len;
		end else if (busy && tick) begin
			ticks_r <= ticks_r + W'(1);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_settle_len: assert property (
		done && len_r != '0 |-> ticks_r == len_r)
		else $error("settle wait ended after the wrong tick count");

	chk_settle_idle: assert property (
		busy && !tick && !start |=> busy && cnt_r == $past(cnt_r))
		else $error("settle count moved without a tick");

endmodule : settle_timer

// >>> testbench/serial_host.sv
`timescale 1ns/1ps
module serial_host (
	output logic sclk,
	output logic cs_n,
	output logic din,
	output logic convert_start_pin_n
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
		convert_start_pin_n = 1'b1;
	end
	// Clock stands still outside frames
	task automatic send_byte(input logic [7:0] b);
		int i;
		#13 cs_n = 1'b0;
		for (i = 7; i >= 0; i--) begin
			din = b[i];
			#32 sclk = 1'b1;
			#32 sclk = 1'b0;
		end
		#32 cs_n = 1'b1;
		// Released line must not keep showing the last bit
		din = ~b[0];
	endtask : send_byte
	// Long enough for the two-flop sync to see it
	task automatic start_pulse();
		convert_start_pin_n = 1'b0;
		#300 convert_start_pin_n = 1'b1;
	endtask : start_pulse
endmodule : serial_host

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import adc_cmd_pkg::*;
	typedef logic [4:0] res_t;
	logic       clk, srst, sclk, cs_n, din, cnv_n;
	logic [7:0] pair_en, other_byte;
	logic [4:0] repeat_count;
	logic       ref_keep_on, conv_ack, conv_req, conv_temp, ref_en;
	logic       scan_busy, scan_done, acq_by_pin, conv_clk_ext;
	logic       top_is_input, secondary_vref_neg, setup_stb, other_stb;
	logic [3:0] conv_chan;
	logic [1:0] vref_mode, pair_cfg_target;
	logic       seen_req;
	int         mismatches, comparisons, cycles, ack_cnt, wait_cnt;
	int         stb_seen;
	res_t       got[$];
	res_t       exp[$];

	serial_host u_host (.sclk(sclk), .cs_n(cs_n), .din(din),
		.convert_start_pin_n(cnv_n));

	// Divide by two so the settle count also sees cycles without a tick
	adc_conv_setup_cmd_decoder #(.INT_DIV(2)) u_dut (
		.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din),
		.convert_start_pin_n(cnv_n), .pair_en(pair_en),
		.repeat_count(repeat_count), .ref_keep_on(ref_keep_on),
		.conv_ack(conv_ack), .conv_req(conv_req), .conv_chan(conv_chan),
		.conv_temp(conv_temp), .ref_en(ref_en), .scan_busy(scan_busy),
		.scan_done(scan_done), .acq_by_pin(acq_by_pin),
		.conv_clk_ext(conv_clk_ext), .top_is_input(top_is_input),
		.vref_mode(vref_mode), .secondary_vref_neg(secondary_vref_neg),
		.pair_cfg_target(pair_cfg_target), .setup_stb(setup_stb),
		.other_stb(other_stb), .other_byte(other_byte));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Converter: answers each request after a few cycles
	always @(posedge clk) begin
		conv_ack <= 1'b0;
		if (conv_req === 1'b1 && conv_ack !== 1'b1) begin
			if (ack_cnt == 3) begin
				conv_ack <= 1'b1;
				got.push_back({conv_temp, conv_chan});
				ack_cnt <= 0;
			end else
				ack_cnt <= ack_cnt + 1;
		end
	end

	// Cycles from scan start to the first request
	always @(posedge clk) begin
		if (scan_busy !== 1'b1) begin
			wait_cnt <= 0;
			seen_req <= 1'b0;
		end else if (!seen_req) begin
			wait_cnt <= wait_cnt + 1;
			seen_req <= (conv_req === 1'b1);
		end
	end

	always @(negedge clk) begin
		if (setup_stb === 1'b1) stb_seen |= 1;
		if (other_stb === 1'b1) stb_seen |= 2;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			$display("MISMATCH at %0t: timeout", $time);
			report_and_stop();
		end
	end

	task automatic check(input logic [7:0] g, input logic [7:0] e,
		input string m);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask : check

	task automatic wr(input logic [7:0] b);
		stb_seen = 0;
		u_host.send_byte(b);
		repeat (6) @(negedge clk);
	endtask : wr

	task automatic run_scan(input int lo, input int hi);
		int i;
		i = 0;
		while (scan_done !== 1'b1 && i < 3000) begin
			@(negedge clk);
			i++;
		end
		check(8'(got.size()), 8'(exp.size()), "result count");
		for (i = 0; i < exp.size() && i < got.size(); i++)
			check({3'h0, got[i]}, {3'h0, exp[i]}, "result");
		check(8'(wait_cnt >= lo && wait_cnt <= hi), 8'h01, "wake");
		repeat (3) @(negedge clk);
		check({7'h0, ref_en}, 8'h00, "reference off after scan");
	endtask : run_scan

	task automatic scan(input logic [7:0] b, input int lo, input int hi);
		got.delete();
		wr(b);
		run_scan(lo, hi);
		$display("TEST scan %h done", b);
	endtask : scan

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	initial begin
		logic [1:0] m;
		srst = 1'b1;
		pair_en = 8'h00;
		repeat_count = 5'h00;
		ref_keep_on = 1'b0;
		conv_ack = 1'b0;
		ack_cnt = 0;
		wait_cnt = 0;
		seen_req = 1'b0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		check({5'h0, acq_by_pin, conv_clk_ext, top_is_input}, 8'h01,
			"clk rst");
		check({4'h0, vref_mode, pair_cfg_target}, 8'h08, "setup rst");
		$display("TEST reset done");
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr({2'b01, m, m, m});
			check(8'(stb_seen), 8'h01, "setup strobe");
			check({7'h0, acq_by_pin}, 8'(i == 1), "pin acq");
			check({7'h0, conv_clk_ext}, 8'(i == 3), "sclk mode");
			check({7'h0, top_is_input}, {7'h0, m[1]}, "top input");
			check({6'h0, vref_mode}, {6'h0, m}, "vref mode");
			check({7'h0, secondary_vref_neg}, {7'h0, m[0]}, "neg ref");
			check({6'h0, pair_cfg_target}, {6'h0, m}, "pair tgt");
		end
		$display("TEST setup modes done");
		wr(8'h2a);
		check(8'(stb_seen), 8'h02, "other strobe");
		check(other_byte, 8'h2a, "other byte");
		check({6'h0, vref_mode}, 8'h03, "setup kept");
		$display("TEST other byte done");
		@(posedge clk) srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		check({5'h0, acq_by_pin, conv_clk_ext, top_is_input}, 8'h01,
			"clk rst again");
		check({4'h0, vref_mode, pair_cfg_target}, 8'h08, "setup rst 2");
		check(other_byte, 8'h00, "other byte rst");
		$display("TEST mid reset done");
		wr(8'h68);
		exp = {5'h10, 5'h00, 5'h01, 5'h02, 5'h03};
		scan(8'h99, 488, 496);
		exp = {5'h05};
		scan(8'hae, 436, 444);
		exp = {5'h0d, 5'h0e, 5'h0f};
		scan(8'hea, 436, 444);
		@(posedge clk) repeat_count <= 5'h03;
		exp = {5'h02, 5'h02, 5'h02};
		scan(8'h94, 436, 444);
		@(posedge clk) pair_en <= 8'h04;
		exp = {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06};
		scan(8'hb0, 436, 444);
		@(posedge clk) pair_en <= 8'h00;
		wr(8'h64);
		exp = {5'h0d, 5'h0f};
		scan(8'hea, 0, 8);
		wr(8'h48);
		got.delete();
		wr(8'hf2);
		repeat (20) @(negedge clk);
		check({7'h0, scan_busy}, 8'h00, "no start on write");
		u_host.start_pulse();
		exp = {5'h0e};
		run_scan(436, 444);
		$display("TEST pin start done");
		@(posedge clk) ref_keep_on <= 1'b1;
		@(negedge clk);
		check({7'h0, ref_en}, 8'h01, "reference held on");
		$display("TEST reference hold done");
		report_and_stop();
	end
endmodule : tb_top
